// file: design/smpfm_defines.vh
/*
  Constants of the pin function mux: register word offsets, field
  positions, reset values and the reset pseudo-vector address.
  Assumes it is included once per file by bare name.
*/
`ifndef SMPFM_DEFINES_VH
`define SMPFM_DEFINES_VH

// Register word offsets on the plain register port
`define SMPFM_OFF_PA_DATA 4'h0
`define SMPFM_OFF_PA_DIR 4'h1
`define SMPFM_OFF_PA_PULL_EN 4'h2
`define SMPFM_OFF_PA_PULL_SEL 4'h3
`define SMPFM_OFF_PA_WAKE_EN 4'h4
`define SMPFM_OFF_PA_ALT_SEL 4'h5
`define SMPFM_OFF_PB_DATA 4'h6
`define SMPFM_OFF_PB_DIR 4'h7
`define SMPFM_OFF_PB_PULL_EN 4'h8
`define SMPFM_OFF_CTRL 4'h9
`define SMPFM_OFF_STATUS 4'ha
`define SMPFM_OFF_MASK 4'hb
`define SMPFM_OFF_MODE 4'hc

// Control register fields
`define SMPFM_CTRL_LF_EN 0
`define SMPFM_CTRL_DBG_DIS 1
`define SMPFM_CTRL_BIT4_DATA 2

// Mode register fields
`define SMPFM_MODE_BDM 0
`define SMPFM_MODE_RUN 1

// Reset values
`define SMPFM_RST_ZERO8 8'h00
`define SMPFM_RST_CTRL 8'h00

// Reset pseudo-vector address, high byte first
`define SMPFM_RESET_VECTOR 16'hdffe

`endif

// file: design/smpfm_pin_cell.v
/*
  One port A pin: output driver mux, pull devices and wake-up edge
  detection. Pin inputs are synchronous to core_clk; every output
  is registered.
*/
`timescale 1ns/1ns
`default_nettype none

module smpfm_pin_cell (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Pin side
  input wire pin_in,
  output reg pin_out,
  output reg pin_oe_n,
  output reg pullup_en,
  output reg pulldown_en,
  // Configuration bits
  input wire data_bit,
  input wire dir_bit,
  input wire pull_en_bit,
  input wire pull_sel_bit,
  input wire wake_en_bit,
  input wire alt_sel_bit,
  // Alternate function side
  input wire alt_drive,
  input wire alt_oe,
  output reg alt_in,
  // Wake-up event pulse
  output reg wake_event
);

  reg prev_pin_r; // Pin level one cycle ago
  reg armed_r; // Previous level is valid
  wire edge_seen; // Active edge this cycle

  // Rising edge when pulldown chosen, else falling edge
  assign edge_seen = pull_sel_bit ? (pin_in & ~prev_pin_r) : (~pin_in & prev_pin_r);

  // Driver, pulls and event detection
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_out <= 1'b0;
      pin_oe_n <= 1'b1;
      pullup_en <= 1'b0;
      pulldown_en <= 1'b0;
      alt_in <= 1'b0;
      wake_event <= 1'b0;
      prev_pin_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      prev_pin_r <= pin_in;
      armed_r <= 1'b1;
      alt_in <= alt_sel_bit & pin_in;
      if (alt_sel_bit) begin
        // Alternate function alone owns the pin driver; pulls still follow the pull bits
        pin_out <= alt_drive;
        pin_oe_n <= ~alt_oe;
      end else begin
        // Plain port driver
        pin_out <= data_bit;
        pin_oe_n <= ~dir_bit;
      end
      pullup_en <= pull_en_bit & ~pull_sel_bit;
      // Pulldown only while wake-up enabled
      pulldown_en <= pull_en_bit & pull_sel_bit & wake_en_bit;
      wake_event <= armed_r & wake_en_bit & ~alt_sel_bit & edge_seen;
    end
  end

endmodule // smpfm_pin_cell

`default_nettype wire

// file: design/smpfm_top.v
/*
  Pin function mux of a sensor microcontroller: port A pins with
  converter and timer routing, keyboard wake-up flags, port B pair,
  low-frequency receiver input pair and the shared debug pin.
  Assumes one clock, pins synchronous to it, and a plain register
  port with read data one cycle after the read strobe.
*/
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "smpfm_defines.vh"

module smpfm_top #(
  parameter PA_WIDTH = 4, // Port A pins with options
  parameter PB_WIDTH = 2 // Port B pins
) (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Port A pins
  input wire [PA_WIDTH-1:0] port_a_in,
  output wire [PA_WIDTH-1:0] port_a_out,
  output wire [PA_WIDTH-1:0] port_a_oe_n,
  output wire [PA_WIDTH-1:0] port_a_pullup_en,
  output wire [PA_WIDTH-1:0] port_a_pulldown_en,
  // Converter channels
  output wire [1:0] adc_channel,
  // Timer channels
  output wire [1:0] timer_ch_in,
  input wire [1:0] timer_ch_out,
  input wire [1:0] timer_ch_oe,
  // Port B pins
  input wire [PB_WIDTH-1:0] port_b_in,
  output reg [PB_WIDTH-1:0] port_b_out,
  output reg [PB_WIDTH-1:0] port_b_oe_n,
  output reg [PB_WIDTH-1:0] port_b_pullup_en,
  // Shared debug pin
  input wire debug_select_pin_in,
  output reg debug_select_pin_out,
  output reg debug_select_pin_oe_n,
  output reg debug_select_pin_pullup_en,
  // Low-frequency receiver pair
  input wire lf_input_pos,
  input wire lf_input_neg,
  output reg lf_receiver_pos,
  output reg lf_receiver_neg,
  output reg lf_receiver_enable,
  // Mode after reset
  output reg background_debug_state,
  output reg cpu_run_start,
  output reg [15:0] reset_vector_addr,
  // Interrupt
  output reg irq
);

  // Software registers
  reg [PA_WIDTH-1:0] pa_data_r; // Port A output data
  reg [PA_WIDTH-1:0] pa_dir_r; // Port A direction, 1 drives
  reg [PA_WIDTH-1:0] pa_pull_en_r; // Port A pull enable
  reg [PA_WIDTH-1:0] pa_pull_sel_r; // Port A pull select, 1 down
  reg [PA_WIDTH-1:0] pa_wake_en_r; // Port A wake-up enable
  reg [PA_WIDTH-1:0] pa_alt_sel_r; // Port A alternate routing
  reg [PB_WIDTH-1:0] pb_data_r; // Port B output data
  reg [PB_WIDTH-1:0] pb_dir_r; // Port B direction
  reg [PB_WIDTH-1:0] pb_pull_en_r; // Port B pullup enable
  reg [7:0] ctrl_r; // Control bits
  reg [PA_WIDTH-1:0] status_r; // Sticky keyboard flags
  reg [PA_WIDTH-1:0] mask_r; // Interrupt mask, 1 passes
  reg [PA_WIDTH-1:0] status_nxt; // Next flag value
  reg [7:0] rdata_nxt; // Read mux result
  reg strap_done_r; // Debug pin sampled after reset

  // Per-pin cell results
  wire [PA_WIDTH-1:0] alt_in_w; // Pin level to alternate function
  wire [PA_WIDTH-1:0] wake_w; // Wake-up edge pulses
  wire [PA_WIDTH-1:0] alt_drive_w; // Alternate output levels
  wire [PA_WIDTH-1:0] alt_oe_w; // Alternate output enables

  // Decoded strobes
  wire status_rd; // Read of the status register
  wire lf_en; // Receiver enable bit
  wire dbg_dis; // Debug disabled bit

  // Address match used by every write and read
  function sel;
    input [3:0] addr;
    input [3:0] off;
    begin
      sel = (addr == off);
    end
  endfunction

  assign status_rd = reg_rd & sel(reg_addr, `SMPFM_OFF_STATUS);
  assign lf_en = ctrl_r[`SMPFM_CTRL_LF_EN];
  assign dbg_dis = ctrl_r[`SMPFM_CTRL_DBG_DIS];

  // Converter pins never drive; timer pins drive from the timer
  assign alt_drive_w = {timer_ch_out, 2'b00};
  assign alt_oe_w = {timer_ch_oe, 2'b00};

  // Low pair to converter, high pair to timer
  assign adc_channel = alt_in_w[1:0];
  assign timer_ch_in = alt_in_w[3:2];

  // One cell per port A pin
  genvar gi;
  generate
    for (gi = 0; gi < PA_WIDTH; gi = gi + 1) begin : g_pin
      smpfm_pin_cell u_cell (
        .core_clk(core_clk),
        .rst(rst),
        .pin_in(port_a_in[gi]),
        .pin_out(port_a_out[gi]),
        .pin_oe_n(port_a_oe_n[gi]),
        .pullup_en(port_a_pullup_en[gi]),
        .pulldown_en(port_a_pulldown_en[gi]),
        .data_bit(pa_data_r[gi]),
        .dir_bit(pa_dir_r[gi]),
        .pull_en_bit(pa_pull_en_r[gi]),
        .pull_sel_bit(pa_pull_sel_r[gi]),
        .wake_en_bit(pa_wake_en_r[gi]),
        .alt_sel_bit(pa_alt_sel_r[gi]),
        .alt_drive(alt_drive_w[gi]),
        .alt_oe(alt_oe_w[gi]),
        .alt_in(alt_in_w[gi]),
        .wake_event(wake_w[gi])
      );
    end
  endgenerate

  // Register writes
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pa_data_r <= {PA_WIDTH{1'b0}};
      pa_dir_r <= {PA_WIDTH{1'b0}};
      pa_pull_en_r <= {PA_WIDTH{1'b0}};
      pa_pull_sel_r <= {PA_WIDTH{1'b0}};
      pa_wake_en_r <= {PA_WIDTH{1'b0}};
      pa_alt_sel_r <= {PA_WIDTH{1'b0}};
      pb_data_r <= {PB_WIDTH{1'b0}};
      pb_dir_r <= {PB_WIDTH{1'b0}};
      pb_pull_en_r <= {PB_WIDTH{1'b0}};
      ctrl_r <= `SMPFM_RST_CTRL;
      mask_r <= {PA_WIDTH{1'b0}};
    end else if (reg_wr) begin
      if (sel(reg_addr, `SMPFM_OFF_PA_DATA)) begin
        pa_data_r <= reg_wdata[PA_WIDTH-1:0];
      end else if (sel(reg_addr, `SMPFM_OFF_PA_DIR)) begin
        pa_dir_r <= reg_wdata[PA_WIDTH-1:0];
      end else if (sel(reg_addr, `SMPFM_OFF_PA_PULL_EN)) begin
        pa_pull_en_r <= reg_wdata[PA_WIDTH-1:0];
      end else if (sel(reg_addr, `SMPFM_OFF_PA_PULL_SEL)) begin
        pa_pull_sel_r <= reg_wdata[PA_WIDTH-1:0];
      end else if (sel(reg_addr, `SMPFM_OFF_PA_WAKE_EN)) begin
        pa_wake_en_r <= reg_wdata[PA_WIDTH-1:0];
      end else if (sel(reg_addr, `SMPFM_OFF_PA_ALT_SEL)) begin
        pa_alt_sel_r <= reg_wdata[PA_WIDTH-1:0];
      end else if (sel(reg_addr, `SMPFM_OFF_PB_DATA)) begin
        pb_data_r <= reg_wdata[PB_WIDTH-1:0];
      end else if (sel(reg_addr, `SMPFM_OFF_PB_DIR)) begin
        pb_dir_r <= reg_wdata[PB_WIDTH-1:0];
      end else if (sel(reg_addr, `SMPFM_OFF_PB_PULL_EN)) begin
        pb_pull_en_r <= reg_wdata[PB_WIDTH-1:0];
      end else if (sel(reg_addr, `SMPFM_OFF_CTRL)) begin
        // Only the three defined bits are kept
        ctrl_r <= {5'b00000, reg_wdata[2:0]};
      end else if (sel(reg_addr, `SMPFM_OFF_MASK)) begin
        mask_r <= reg_wdata[PA_WIDTH-1:0];
      end
    end
  end

  // Sticky keyboard flags: read clears, new event wins
  always @* begin
    status_nxt = status_r;
    if (status_rd) begin
      status_nxt = {PA_WIDTH{1'b0}};
    end
    status_nxt = status_nxt | wake_w;
  end

  // Flags and interrupt level
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_r <= {PA_WIDTH{1'b0}};
      irq <= 1'b0;
    end else begin
      status_r <= status_nxt;
      irq <= |(status_nxt & mask_r);
    end
  end

  // Read mux
  always @* begin
    rdata_nxt = `SMPFM_RST_ZERO8;
    if (sel(reg_addr, `SMPFM_OFF_PA_DATA)) begin
      // Pin levels as seen at the pins
      rdata_nxt[PA_WIDTH-1:0] = port_a_in;
    end else if (sel(reg_addr, `SMPFM_OFF_PA_DIR)) begin
      rdata_nxt[PA_WIDTH-1:0] = pa_dir_r;
    end else if (sel(reg_addr, `SMPFM_OFF_PA_PULL_EN)) begin
      rdata_nxt[PA_WIDTH-1:0] = pa_pull_en_r;
    end else if (sel(reg_addr, `SMPFM_OFF_PA_PULL_SEL)) begin
      rdata_nxt[PA_WIDTH-1:0] = pa_pull_sel_r;
    end else if (sel(reg_addr, `SMPFM_OFF_PA_WAKE_EN)) begin
      rdata_nxt[PA_WIDTH-1:0] = pa_wake_en_r;
    end else if (sel(reg_addr, `SMPFM_OFF_PA_ALT_SEL)) begin
      rdata_nxt[PA_WIDTH-1:0] = pa_alt_sel_r;
    end else if (sel(reg_addr, `SMPFM_OFF_PB_DATA)) begin
      // Port B pair reads zero while high-Z for the receiver
      rdata_nxt[PB_WIDTH-1:0] = lf_en ? {PB_WIDTH{1'b0}} : port_b_in;
    end else if (sel(reg_addr, `SMPFM_OFF_PB_DIR)) begin
      rdata_nxt[PB_WIDTH-1:0] = pb_dir_r;
    end else if (sel(reg_addr, `SMPFM_OFF_PB_PULL_EN)) begin
      rdata_nxt[PB_WIDTH-1:0] = pb_pull_en_r;
    end else if (sel(reg_addr, `SMPFM_OFF_CTRL)) begin
      rdata_nxt = ctrl_r;
    end else if (sel(reg_addr, `SMPFM_OFF_STATUS)) begin
      rdata_nxt[PA_WIDTH-1:0] = status_r;
    end else if (sel(reg_addr, `SMPFM_OFF_MASK)) begin
      rdata_nxt[PA_WIDTH-1:0] = mask_r;
    end else if (sel(reg_addr, `SMPFM_OFF_MODE)) begin
      rdata_nxt[`SMPFM_MODE_BDM] = background_debug_state;
      rdata_nxt[`SMPFM_MODE_RUN] = strap_done_r & ~background_debug_state;
    end
  end

  // Read data stands one cycle after the strobe only
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= `SMPFM_RST_ZERO8;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= `SMPFM_RST_ZERO8;
    end
  end

  // Port B pair drivers
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      port_b_out <= {PB_WIDTH{1'b0}};
      port_b_oe_n <= {PB_WIDTH{1'b1}};
      port_b_pullup_en <= {PB_WIDTH{1'b0}};
    end else if (lf_en) begin
      // Receiver owns the pair: no driver, no pull
      port_b_out <= {PB_WIDTH{1'b0}};
      port_b_oe_n <= {PB_WIDTH{1'b1}};
      port_b_pullup_en <= {PB_WIDTH{1'b0}};
    end else begin
      // Plain port with pullup only
      port_b_out <= pb_data_r;
      port_b_oe_n <= ~pb_dir_r;
      port_b_pullup_en <= pb_pull_en_r;
    end
  end

  // Low-frequency receiver input gating
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lf_receiver_pos <= 1'b0;
      lf_receiver_neg <= 1'b0;
      lf_receiver_enable <= 1'b0;
    end else begin
      lf_receiver_pos <= lf_en & lf_input_pos;
      lf_receiver_neg <= lf_en & lf_input_neg;
      lf_receiver_enable <= lf_en;
    end
  end

  // Debug pin strap caught at the first edge after release
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strap_done_r <= 1'b0;
      background_debug_state <= 1'b0;
      cpu_run_start <= 1'b0;
      reset_vector_addr <= `SMPFM_RESET_VECTOR;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      // Low pin selects debug mode
      background_debug_state <= ~debug_select_pin_in;
      // High pin starts the program from the vector
      cpu_run_start <= debug_select_pin_in;
    end else begin
      cpu_run_start <= 1'b0;
    end
  end

  // Shared debug pin driver
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      debug_select_pin_out <= 1'b0;
      debug_select_pin_oe_n <= 1'b1;
      debug_select_pin_pullup_en <= 1'b1;
    end else begin
      // Pullup stays on in every mode
      debug_select_pin_pullup_en <= 1'b1;
      if (dbg_dis && !background_debug_state) begin
        // Output-only port bit 4
        debug_select_pin_out <= ctrl_r[`SMPFM_CTRL_BIT4_DATA];
        debug_select_pin_oe_n <= 1'b0;
      end else begin
        debug_select_pin_out <= 1'b0;
        debug_select_pin_oe_n <= 1'b1;
      end
    end
  end

endmodule // smpfm_top

`default_nettype wire

// file: testbench/smpfm_pad.sv
/*
  Board side of a group of pins: resolves each wire from the device
  drive, an external driver, and the pull devices.
  Assumes the enables come from the device's registered outputs.
*/
`timescale 1ns/1ns
`default_nettype none

module smpfm_pad #(
  parameter W = 1 // Pins in this group
) (
  // Clock
  input wire logic core_clk,
  // Device side
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] oe_n,
  input wire logic [W-1:0] pu,
  input wire logic [W-1:0] pd,
  // Board drivers
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_val,
  // Wire level
  output logic [W-1:0] lvl
);
  logic [W-1:0] last_r = '0; // Last level, for floating pins

  // Device drive first, then board, then pulls
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!oe_n[i])
        lvl[i] = out[i];
      else if (ext_en[i])
        lvl[i] = ext_val[i];
      else if (pu[i])
        lvl[i] = 1'b1;
      else if (pd[i])
        lvl[i] = 1'b0;
      else
        lvl[i] = ~last_r[i];
    end
  end

  // Floating wire flips each cycle, never a stale value
  always @(posedge core_clk) begin
    last_r <= lvl;
  end
endmodule // smpfm_pad

`default_nettype wire

// file: testbench/smpfm_top_properties.sv
/*
  Port checker of the pin mux top.
  Assumes it is bound into smpfm_top, one clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
`include "smpfm_defines.vh"

module smpfm_props #(
  parameter PA_WIDTH = 4, // Port A pins
  parameter PB_WIDTH = 2 // Port B pins
) (
  // Clock, reset, register port
  input wire core_clk,
  input wire rst,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // Port pins
  input wire [PA_WIDTH-1:0] port_a_in,
  input wire [PA_WIDTH-1:0] port_a_pullup_en,
  input wire [PA_WIDTH-1:0] port_a_pulldown_en,
  input wire [1:0] adc_channel,
  input wire [1:0] timer_ch_in,
  input wire [PB_WIDTH-1:0] port_b_out,
  input wire [PB_WIDTH-1:0] port_b_oe_n,
  input wire [PB_WIDTH-1:0] port_b_pullup_en,
  // Debug pin and modes
  input wire debug_select_pin_in,
  input wire debug_select_pin_oe_n,
  input wire debug_select_pin_pullup_en,
  input wire background_debug_state,
  input wire cpu_run_start,
  input wire [15:0] reset_vector_addr,
  // Receiver pair
  input wire lf_input_pos,
  input wire lf_receiver_pos,
  input wire lf_receiver_enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  pull_excl_a: assert property (
    (port_a_pulldown_en & port_a_pullup_en) == 0) else $error("pullup and pulldown both on");
  adc_level_a: assert property (
    (adc_channel & ~($past(port_a_in[1:0]) | $past(port_a_in[1:0], 2))) == 0) else $error("adc bit without pin");
  timer_level_a: assert property (
    (timer_ch_in & ~($past(port_a_in[3:2]) | $past(port_a_in[3:2], 2))) == 0) else $error("timer bit without pin");
  lf_off_a: assert property (
    !lf_receiver_enable && !$past(lf_receiver_enable) |-> !lf_receiver_pos) else $error("receiver live while off");
  lf_pass_a: assert property (
    lf_receiver_pos |-> $past(lf_input_pos) || $past(lf_input_pos, 2)) else $error("receiver without input");
  pb_hiz_a: assert property (
    lf_receiver_enable && $past(lf_receiver_enable) |-> &port_b_oe_n && port_b_out == 0 && port_b_pullup_en == 0)
    else $error("port b not released");
  dbg_pull_a: assert property (debug_select_pin_pullup_en) else $error("debug pullup off");
  bdm_entry_a: assert property (
    $rose(background_debug_state) |-> !$past(debug_select_pin_in)) else $error("debug state without low pin");
  run_start_a: assert property (
    cpu_run_start |-> $past(debug_select_pin_in) && !background_debug_state ##1 !cpu_run_start)
    else $error("bad run start");
  bit4_out_a: assert property (
    !debug_select_pin_oe_n |-> !background_debug_state) else $error("bit4 driven in debug state");
  vector_fix_a: assert property (
    reset_vector_addr == `SMPFM_RESET_VECTOR) else $error("wrong reset vector");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside slot");
endmodule // smpfm_props

bind smpfm_top smpfm_props #(.PA_WIDTH(PA_WIDTH), .PB_WIDTH(PB_WIDTH)) u_props (.core_clk, .rst, .reg_rd,
  .reg_rdata, .port_a_in, .port_a_pullup_en, .port_a_pulldown_en, .adc_channel, .timer_ch_in, .port_b_out,
  .port_b_oe_n, .port_b_pullup_en, .debug_select_pin_in, .debug_select_pin_oe_n, .debug_select_pin_pullup_en,
  .background_debug_state, .cpu_run_start, .reset_vector_addr, .lf_input_pos, .lf_receiver_pos,
  .lf_receiver_enable);

`default_nettype wire

// file: testbench/smpfm_top_tb.sv
/*
  Bench of the pin mux: register tasks, board pads and scenarios.
  Assumes the pad model and the checker are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "smpfm_defines.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module smpfm_top_tb;
  logic core_clk = 1'b0; // Clock
  logic rst = 1'b1; // Reset
  logic [3:0] reg_addr = 4'h0; // Register port
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [3:0] port_a_in, port_a_out, port_a_oe_n, port_a_pullup_en, port_a_pulldown_en;
  logic [1:0] adc_channel, timer_ch_in, port_b_in, port_b_out, port_b_oe_n, port_b_pullup_en;
  logic [1:0] timer_ch_out = 2'h0; // Timer side
  logic [1:0] timer_ch_oe = 2'h0;
  logic debug_select_pin_in, debug_select_pin_out, debug_select_pin_oe_n, debug_select_pin_pullup_en;
  logic lf_input_pos = 1'b0; // Coil pair
  logic lf_input_neg = 1'b0;
  logic lf_receiver_pos, lf_receiver_neg, lf_receiver_enable, background_debug_state, cpu_run_start, irq;
  logic [15:0] reset_vector_addr;
  logic [3:0] a_en = 4'h0; // Board drive on port A
  logic [3:0] a_val = 4'h0;
  logic dbg_low = 1'b0; // Host pulls debug pin low
  logic [1:0] b_en = 2'h0; // Board drive on port B
  logic [1:0] b_val = 2'h0;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;

  smpfm_top uut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .port_a_in, .port_a_out,
    .port_a_oe_n, .port_a_pullup_en, .port_a_pulldown_en, .adc_channel, .timer_ch_in, .timer_ch_out,
    .timer_ch_oe, .port_b_in, .port_b_out, .port_b_oe_n, .port_b_pullup_en, .debug_select_pin_in,
    .debug_select_pin_out, .debug_select_pin_oe_n, .debug_select_pin_pullup_en, .lf_input_pos, .lf_input_neg,
    .lf_receiver_pos, .lf_receiver_neg, .lf_receiver_enable, .background_debug_state, .cpu_run_start,
    .reset_vector_addr, .irq);
  smpfm_pad #(.W(4)) pad_a (.core_clk, .out(port_a_out), .oe_n(port_a_oe_n), .pu(port_a_pullup_en),
    .pd(port_a_pulldown_en), .ext_en(a_en), .ext_val(a_val), .lvl(port_a_in));
  smpfm_pad #(.W(2)) pad_b (.core_clk, .out(port_b_out), .oe_n(port_b_oe_n), .pu(port_b_pullup_en),
    .pd(2'h0), .ext_en(b_en), .ext_val(b_val), .lvl(port_b_in));
  smpfm_pad #(.W(1)) pad_d (.core_clk, .out(debug_select_pin_out), .oe_n(debug_select_pin_oe_n),
    .pu(debug_select_pin_pullup_en), .pd(1'b0), .ext_en(dbg_low), .ext_val(~dbg_low), .lvl(debug_select_pin_in));

  // Free-running clock
  initial forever #50 core_clk = ~core_clk;

  // Hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      summarize;
    end
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // One-cycle read strobe, data judged in the following cycle
  task automatic rdc(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata & m, e)
  endtask

  task automatic t_boot;
    `CHK(reset_vector_addr, `SMPFM_RESET_VECTOR)
    `CHK(cpu_run_start, 1'b1)
    `CHK({debug_select_pin_pullup_en, debug_select_pin_in}, 2'h3)
    `CHK(background_debug_state, 1'b0)
    rdc(`SMPFM_OFF_MODE, 8'h02);
    rdc(4'hf, 8'h00);
  endtask

  task automatic t_pulls;
    wr(`SMPFM_OFF_PA_PULL_EN, 8'h0f);
    wr(`SMPFM_OFF_PA_PULL_SEL, 8'h0f);
    tick(2);
    `CHK({port_a_pullup_en, port_a_pulldown_en}, 8'h00)
    wr(`SMPFM_OFF_PA_WAKE_EN, 8'h05);
    tick(2);
    `CHK(port_a_pulldown_en, 4'h5)
    rdc(`SMPFM_OFF_PA_WAKE_EN, 8'h05);
    rdc(`SMPFM_OFF_PA_PULL_SEL, 8'h0f);
    wr(`SMPFM_OFF_PA_PULL_SEL, 8'h00);
    tick(2);
    `CHK({port_a_pullup_en, port_a_pulldown_en}, 8'hf0)
    rdc(`SMPFM_OFF_PA_PULL_EN, 8'h0f);
  endtask

  task automatic t_route;
    wr(`SMPFM_OFF_PA_DIR, 8'h0f);
    wr(`SMPFM_OFF_PA_ALT_SEL, 8'h0f);
    timer_ch_oe <= 2'h3;
    timer_ch_out <= 2'h2;
    a_en <= 4'h3;
    a_val <= 4'h1;
    tick(4);
    `CHK(port_a_oe_n, 4'h3)
    `CHK({port_a_out[3:2], timer_ch_in}, 4'ha)
    `CHK(adc_channel, 2'h1)
    rdc(`SMPFM_OFF_PA_DATA, 8'h09);
    rdc(`SMPFM_OFF_PA_ALT_SEL, 8'h0f);
    rdc(`SMPFM_OFF_PA_DIR, 8'h0f);
    a_en <= 4'h0;
    wr(`SMPFM_OFF_PA_ALT_SEL, 8'h00);
    tick(3);
    `CHK(port_a_oe_n, 4'h0)
    `CHK(adc_channel, 2'h0)
    wr(`SMPFM_OFF_PA_DIR, 8'h00);
  endtask

  task automatic t_wake;
    a_val <= 4'h0;
    wr(`SMPFM_OFF_PA_WAKE_EN, 8'h0f);
    wr(`SMPFM_OFF_MASK, 8'h0f);
    tick(3);
    rdc(`SMPFM_OFF_STATUS, 8'h00, 8'hf0);
    rdc(`SMPFM_OFF_STATUS, 8'h00);
    `CHK(irq, 1'b0)
    rdc(`SMPFM_OFF_MASK, 8'h0f);
    for (int i = 0; i < 4; i++) begin
      a_en <= 4'h1 << i;
      tick(4);
      `CHK(irq, 1'b1)
      rdc(`SMPFM_OFF_STATUS, 8'h01 << i);
      a_en <= 4'h0;
      tick(3);
      `CHK(irq, 1'b0)
    end
    wr(`SMPFM_OFF_MASK, 8'h00);
    a_en <= 4'h1;
    tick(4);
    `CHK(irq, 1'b0)
    rdc(`SMPFM_OFF_STATUS, 8'h01);
    a_en <= 4'h0;
  endtask

  task automatic t_lf;
    wr(`SMPFM_OFF_PB_DIR, 8'h03);
    wr(`SMPFM_OFF_PB_DATA, 8'h02);
    wr(`SMPFM_OFF_PB_PULL_EN, 8'h03);
    tick(2);
    `CHK({port_b_oe_n, port_b_out, port_b_pullup_en}, 6'h0b)
    rdc(`SMPFM_OFF_PB_DATA, 8'h02);
    rdc(`SMPFM_OFF_PB_PULL_EN, 8'h03);
    wr(`SMPFM_OFF_CTRL, 8'h01);
    lf_input_pos <= 1'b1;
    lf_input_neg <= 1'b1;
    tick(3);
    `CHK({port_b_oe_n, port_b_out, port_b_pullup_en}, 6'h30)
    `CHK({lf_receiver_enable, lf_receiver_pos, lf_receiver_neg}, 3'h7)
    rdc(`SMPFM_OFF_CTRL, 8'h01);
    rdc(`SMPFM_OFF_PB_DATA, 8'h00);
    wr(`SMPFM_OFF_CTRL, 8'h00);
    tick(3);
    `CHK({lf_receiver_enable, lf_receiver_pos, lf_receiver_neg}, 3'h0)
    `CHK(port_b_oe_n, 2'h0)
    b_en <= 2'h3;
    b_val <= 2'h1;
    wr(`SMPFM_OFF_PB_DIR, 8'h00);
    rdc(`SMPFM_OFF_PB_DATA, 8'h01);
    b_en <= 2'h0;
  endtask

  task automatic t_dbg;
    wr(`SMPFM_OFF_CTRL, 8'hfe);
    rdc(`SMPFM_OFF_CTRL, 8'h06);
    tick(2);
    `CHK({debug_select_pin_oe_n, debug_select_pin_out}, 2'h1)
    wr(`SMPFM_OFF_CTRL, 8'h00);
    tick(2);
    `CHK(debug_select_pin_oe_n, 1'b1)
    dbg_low <= 1'b1;
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(3);
    dbg_low <= 1'b0;
    `CHK(background_debug_state, 1'b1)
    `CHK(cpu_run_start, 1'b0)
    rdc(`SMPFM_OFF_MODE, 8'h01);
    wr(`SMPFM_OFF_CTRL, 8'h06);
    tick(2);
    `CHK(debug_select_pin_oe_n, 1'b1)
  endtask

  // Main sequence
  initial begin
    tick(3);
    rst <= 1'b0;
    tick(1);
    t_boot;
    t_pulls;
    t_route;
    t_wake;
    t_lf;
    t_dbg;
    summarize;
  end
endmodule // smpfm_top_tb

`default_nettype wire
